// [logic/eersd_regs.vh]
// constants of the serial eeprom reset and default block
`ifndef EERSD_REGS_VH
`define EERSD_REGS_VH

// opcodes, bit 3 is a don't-care
`define EERSD_OPC_MASK 8'hf7
`define EERSD_OPC_SETWEL 8'h06
`define EERSD_OPC_CLRWEL 8'h04
`define EERSD_OPC_RDSTAT 8'h05
`define EERSD_OPC_WRSTAT 8'h01
`define EERSD_OPC_READ 8'h03
`define EERSD_OPC_WRITE 8'h02

// status register bit positions
`define EERSD_ST_BUSY 0
`define EERSD_ST_WEL 1
`define EERSD_ST_BP0 2
`define EERSD_ST_BP1 3
`define EERSD_ST_PPEN 7

// shipped contents
`define EERSD_ARRAY_FILL 8'hff
`define EERSD_PPEN_SHIP 1'b0
`define EERSD_BP_SHIP 2'h0

// geometry
`define EERSD_ADDR_W 15
`define EERSD_PAGE_W 6

// timing: core clock, self-timed write and first-instruction wait
`define EERSD_CLK_MHZ 250
`define EERSD_WRITE_MS 5
`define EERSD_FIRST_INSTR_WAIT_US 100

`endif

// [logic/eersd_core.v]
// serial eeprom spi slave: power-up defaults, interface reset, nonvolatile status and array
`timescale 1ns/1ps
`include "eersd_regs.vh"

// Operation
// - clockless select toggle resets interface, next opcode
// - leave reset in standby, deselected, not held
// - become active only on select falling edge
// - write enable latch cleared at power-up
// - busy bit reads zero after power-up
// - protect bits nonvolatile, kept over resets
// - shipped array reads all ones
// - shipped protect bits are zero
// - protect pin ignored while its enable clear
// - instructions ignored during power-on reset
// - deselected: input ignored, output released
// - eight-bit msb-first opcodes, bit three ignored
module eersd_core #(
	parameter ADDR_W = `EERSD_ADDR_W,
	parameter PAGE_W = `EERSD_PAGE_W,
	parameter WRITE_CYCLES = `EERSD_WRITE_MS * 1000 * `EERSD_CLK_MHZ
)
(
	input wire clk_i,
	input wire rst_i,
	input wire csel_n_i,
	input wire sck_i,
	input wire si_i,
	input wire wp_n_i,
	output reg so_o,
	output reg so_oe_o,
	output reg write_enable_latch_o,
	output reg busy_o,
	output reg protect_pin_enable_o,
	output reg [1:0] block_protect_o,
	output reg standby_o,
	output reg iface_reset_o
);

localparam DEPTH = 1 << ADDR_W;
localparam PAGE = 1 << PAGE_W;
localparam [7:0] ST_IDLE = 8'h01;
localparam [7:0] ST_OPC = 8'h02;
localparam [7:0] ST_ADDR = 8'h04;
localparam [7:0] ST_RDATA = 8'h08;
localparam [7:0] ST_WDATA = 8'h10;
localparam [7:0] ST_STATW = 8'h20;
localparam [7:0] ST_STATR = 8'h40;
localparam [7:0] ST_IGNORE = 8'h80;

function opc_is;
	input [7:0] opc;
	input [7:0] code;
	begin
		opc_is = ((opc & `EERSD_OPC_MASK) == code);
	end
endfunction

// upper quarter, upper half or all of the array per block-protect code
function addr_locked;
	input [1:0] bp;
	input [ADDR_W-1:0] a;
	begin
		case (bp)
			2'h1: addr_locked = (a[ADDR_W-1:ADDR_W-2] == 2'h3);
			2'h2: addr_locked = a[ADDR_W-1];
			2'h3: addr_locked = 1'b1;
			default: addr_locked = 1'b0;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// storage; contents and protect bits are not touched by rst_i

reg [7:0] mem [0:DEPTH-1];
reg [7:0] page_buf [0:PAGE-1];
reg [PAGE-1:0] page_mask_q;
integer i;

initial
begin
	for (i = 0; i < DEPTH; i = i + 1)
		mem[i] = `EERSD_ARRAY_FILL;
	protect_pin_enable_o = `EERSD_PPEN_SHIP;
	block_protect_o = `EERSD_BP_SHIP;
end

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers and edge detection
reg cs_s1_q, cs_s2_q, cs_s3_q;
reg sck_s1_q, sck_s2_q, sck_s3_q;
reg si_s1_q, si_s2_q;
reg wp_s1_q, wp_s2_q;
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		// idle levels, so no false select or clock edge follows reset
		{cs_s3_q, cs_s2_q, cs_s1_q} <= 3'h7;
		{sck_s3_q, sck_s2_q, sck_s1_q} <= 3'h0;
		{si_s2_q, si_s1_q} <= 2'h0;
		{wp_s2_q, wp_s1_q} <= 2'h3;
	end
	else
	begin
		{cs_s3_q, cs_s2_q, cs_s1_q} <= {cs_s2_q, cs_s1_q, csel_n_i};
		{sck_s3_q, sck_s2_q, sck_s1_q} <= {sck_s2_q, sck_s1_q, sck_i};
		{si_s2_q, si_s1_q} <= {si_s1_q, si_i};
		{wp_s2_q, wp_s1_q} <= {wp_s1_q, wp_n_i};
	end
end
wire cs_fall = cs_s3_q & ~cs_s2_q;
wire cs_rise = ~cs_s3_q & cs_s2_q;
wire sck_rise = ~sck_s3_q & sck_s2_q;
wire sck_fall = sck_s3_q & ~sck_s2_q;

////////////////////////////////////////////////////////////////////////////////
// serial front end

reg [7:0] state_q;
reg armed_q;
reg clk_seen_q;
reg [2:0] bit_cnt_q;
reg [6:0] shift_q;
reg addr_byte_q;
reg is_read_q;
reg [ADDR_W-1:0] addr_q;
reg [7:0] out_q;
reg [7:0] stat_new_q;
reg stat_pend_q;
reg [ADDR_W-1:0] cm_base_q;
reg [31:0] wr_cnt_q;
reg wr_stat_q;
wire [7:0] in_byte = {shift_q, si_s2_q};
wire byte_done = (bit_cnt_q == 3'h7);
wire [7:0] status_now = {protect_pin_enable_o, 3'h0, block_protect_o, write_enable_latch_o, busy_o};
wire [ADDR_W-1:0] addr_next = addr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
wire pin_locks = protect_pin_enable_o & ~wp_s2_q;
// a write starts only when select rises on a byte boundary after whole bytes
wire start_arr = cs_rise & (state_q == ST_WDATA) & (bit_cnt_q == 3'h0) & (|page_mask_q);
wire start_stat = cs_rise & (state_q == ST_STATW) & (bit_cnt_q == 3'h0) & stat_pend_q;
wire arr_ok = write_enable_latch_o & ~addr_locked(block_protect_o, addr_q);
wire stat_ok = write_enable_latch_o & ~pin_locks;

always @(posedge clk_i)
begin
	if (rst_i)
	begin
		state_q <= ST_IDLE;
		armed_q <= 1'b0;
		{clk_seen_q, addr_byte_q, is_read_q, stat_pend_q} <= 4'h0;
		bit_cnt_q <= 3'h0;
		shift_q <= 7'h00;
		addr_q <= {ADDR_W{1'b0}};
		{out_q, stat_new_q} <= 16'h0000;
		page_mask_q <= {PAGE{1'b0}};
		write_enable_latch_o <= 1'b0;
		so_o <= 1'b0;
		so_oe_o <= 1'b0;
		standby_o <= 1'b1;
		iface_reset_o <= 1'b0;
	end
	else
	begin
		iface_reset_o <= 1'b0;
		if (cs_fall)
		begin
			// only a falling select starts a frame after reset
			armed_q <= 1'b1;
			state_q <= ST_OPC;
			clk_seen_q <= 1'b0;
			bit_cnt_q <= 3'h0;
			standby_o <= 1'b0;
			stat_pend_q <= 1'b0;
			page_mask_q <= {PAGE{1'b0}};
		end
		else if (cs_rise)
		begin
			state_q <= ST_IDLE;
			bit_cnt_q <= 3'h0;
			so_oe_o <= 1'b0;
			standby_o <= 1'b1;
			iface_reset_o <= armed_q & ~clk_seen_q;
			if (start_arr | start_stat)
				write_enable_latch_o <= 1'b0;
		end
		else if (armed_q && !cs_s2_q && sck_rise && state_q != ST_IDLE)
		begin
			clk_seen_q <= 1'b1;
			shift_q <= in_byte[6:0];
			bit_cnt_q <= bit_cnt_q + 3'h1;
			if (byte_done)
			begin
				case (state_q)
					ST_OPC:
					begin
						addr_byte_q <= 1'b0;
						state_q <= ST_IGNORE;
						if (opc_is(in_byte, `EERSD_OPC_RDSTAT))
						begin
							out_q <= status_now;
							state_q <= ST_STATR;
						end
						else if (!busy_o)
						begin
							if (opc_is(in_byte, `EERSD_OPC_SETWEL))
								write_enable_latch_o <= 1'b1;
							else if (opc_is(in_byte, `EERSD_OPC_CLRWEL))
								write_enable_latch_o <= 1'b0;
							else if (opc_is(in_byte, `EERSD_OPC_WRSTAT))
								state_q <= ST_STATW;
							else if (opc_is(in_byte, `EERSD_OPC_READ))
							begin
								is_read_q <= 1'b1;
								state_q <= ST_ADDR;
							end
							else if (opc_is(in_byte, `EERSD_OPC_WRITE))
							begin
								is_read_q <= 1'b0;
								state_q <= ST_ADDR;
							end
						end
					end
					ST_ADDR:
					begin
						addr_byte_q <= 1'b1;
						if (!addr_byte_q)
							addr_q <= {in_byte[ADDR_W-9:0], addr_q[7:0]};
						else if (is_read_q)
						begin
							out_q <= mem[{addr_q[ADDR_W-1:8], in_byte}];
							addr_q <= {addr_q[ADDR_W-1:8], in_byte} + {{(ADDR_W-1){1'b0}}, 1'b1};
							state_q <= ST_RDATA;
						end
						else
						begin
							addr_q <= {addr_q[ADDR_W-1:8], in_byte};
							state_q <= ST_WDATA;
						end
					end
					ST_RDATA:
					begin
						out_q <= mem[addr_q];
						addr_q <= addr_next;
					end
					ST_STATR:
						out_q <= status_now;
					ST_WDATA:
					begin
						page_mask_q[addr_q[PAGE_W-1:0]] <= 1'b1;
						// offset wraps inside the page
						addr_q <= {addr_q[ADDR_W-1:PAGE_W], addr_next[PAGE_W-1:0]};
					end
					ST_STATW:
					begin
						stat_new_q <= in_byte;
						stat_pend_q <= 1'b1;
					end
					default:
						state_q <= state_q;
				endcase
			end
		end
		else if (!cs_s2_q && sck_fall && (state_q == ST_RDATA || state_q == ST_STATR))
		begin
			so_o <= out_q[~bit_cnt_q];
			so_oe_o <= 1'b1;
		end
	end
end

// data bytes park in the page buffer until select rises
always @(posedge clk_i)
begin
	if (armed_q && !cs_s2_q && sck_rise && byte_done && state_q == ST_WDATA)
		page_buf[addr_q[PAGE_W-1:0]] <= in_byte;
end

////////////////////////////////////////////////////////////////////////////////
// self-timed write; page copy rides on the first page-size counts

reg [PAGE-1:0] cm_mask_q;

always @(posedge clk_i)
begin
	if (rst_i)
	begin
		busy_o <= 1'b0;
		wr_cnt_q <= 32'h0;
		wr_stat_q <= 1'b0;
		cm_base_q <= {ADDR_W{1'b0}};
		cm_mask_q <= {PAGE{1'b0}};
	end
	else if (!busy_o)
	begin
		if (start_arr && arr_ok)
		begin
			busy_o <= 1'b1;
			wr_cnt_q <= 32'h0;
			wr_stat_q <= 1'b0;
			cm_base_q <= {addr_q[ADDR_W-1:PAGE_W], {PAGE_W{1'b0}}};
			cm_mask_q <= page_mask_q;
		end
		else if (start_stat && stat_ok)
		begin
			busy_o <= 1'b1;
			wr_cnt_q <= 32'h0;
			wr_stat_q <= 1'b1;
			cm_mask_q <= {PAGE{1'b0}};
		end
	end
	else
	begin
		wr_cnt_q <= wr_cnt_q + 32'h1;
		if (wr_cnt_q == WRITE_CYCLES - 1)
			busy_o <= 1'b0;
	end
end

// nonvolatile: no reset term, only a finished status write changes them
always @(posedge clk_i)
begin
	if (busy_o && wr_stat_q && wr_cnt_q == WRITE_CYCLES - 1)
	begin
		protect_pin_enable_o <= stat_new_q[`EERSD_ST_PPEN];
		block_protect_o <= {stat_new_q[`EERSD_ST_BP1], stat_new_q[`EERSD_ST_BP0]};
	end
end
wire [PAGE_W-1:0] cm_idx = wr_cnt_q[PAGE_W-1:0];

always @(posedge clk_i)
begin
	if (busy_o && !wr_stat_q && wr_cnt_q < PAGE && cm_mask_q[cm_idx])
		mem[cm_base_q | {{(ADDR_W-PAGE_W){1'b0}}, cm_idx}] <= page_buf[cm_idx];
end

endmodule

// [test/eersd_checker.sv]
// checker on the eeprom reset and default ports
`timescale 1ns/1ps
module eersd_checker #(
	parameter WRITE_CYCLES = 100
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic csel_n_i,
	input wire logic sck_i,
	input wire logic si_i,
	input wire logic wp_n_i,
	input wire logic so_o,
	input wire logic so_oe_o,
	input wire logic write_enable_latch_o,
	input wire logic busy_o,
	input wire logic protect_pin_enable_o,
	input wire logic [1:0] block_protect_o,
	input wire logic standby_o,
	input wire logic iface_reset_o
);
	localparam int BLO = WRITE_CYCLES - 2;
	localparam int BHI = WRITE_CYCLES + 2;
	default clocking @(posedge clk_i); endclocking
	////////////////////////////////////////////////////////////////
	AST_RST_STANDBY: assert property (rst_i |=> standby_o && !so_oe_o && !so_o)
		else $error("not idle after reset");
	AST_RST_WEL: assert property (rst_i |=> !write_enable_latch_o)
		else $error("latch set after reset");
	AST_RST_BUSY: assert property (rst_i |=> !busy_o && !iface_reset_o)
		else $error("busy after reset");
	AST_NV_KEEP: assert property (rst_i |=> $stable(protect_pin_enable_o) && $stable(block_protect_o))
		else $error("protect bits lost on reset");
	AST_DESEL_OE: assert property (disable iff (rst_i) csel_n_i [*6] |-> !so_oe_o && standby_o)
		else $error("output driven while deselected");
	AST_IRST_PULSE: assert property (disable iff (rst_i) iface_reset_o |=> !iface_reset_o)
		else $error("interface reset too long");
	AST_IRST_DESEL: assert property (disable iff (rst_i) iface_reset_o |-> csel_n_i && $past(csel_n_i))
		else $error("interface reset while selected");
	AST_BUSY_LEN: assert property (disable iff (rst_i) $rose(busy_o) |-> ##[BLO:BHI] $fell(busy_o))
		else $error("write cycle length wrong");
	////////////////////////////////////////////////////////////////
	cover property (iface_reset_o);
	cover property ($rose(busy_o));
	cover property ($rose(so_oe_o));
	cover property ($fell(write_enable_latch_o));
endmodule

// [test/eersd_master.sv]
// spi master model driving the eeprom serial pins
`timescale 1ns/1ps
module eersd_master
(
	input wire logic clk_i,
	input wire logic so_i,
	input wire logic so_oe_i,
	output logic csel_n_o,
	output logic sck_o,
	output logic si_o
);
	initial
	begin
		csel_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
	end
	task tick(input integer n);
		repeat (n) @(posedge clk_i);
	endtask
	// gaps well above the 4 clk minimum; no sck between select edges
	task sel(input bit on);
		tick(10);
		csel_n_o <= ~on;
		if (!on)
			si_o <= ~si_o;
		tick(10);
	endtask
	// mode 0, msb first, 80 ns sck period
	task xfer(input [7:0] tx, input integer nb, output [7:0] rx);
		integer i;
		for (i = 7; i >= 8 - nb; i = i - 1)
		begin
			si_o <= tx[i];
			tick(10);
			sck_o <= 1'b1;
			rx[i] = so_oe_i ? so_i : 1'bx;
			tick(10);
			sck_o <= 1'b0;
		end
	endtask
endmodule

// [test/tb.sv]
// testbench: power-up defaults, interface reset, shipped contents
`timescale 1ns/1ps
module tb;
	localparam WC = 100;
	localparam int PUP_CYC = 100 * 250; // first_instruction_wait in clk_i cycles
	logic clk_i, rst_i, wp_n_i;
	logic irst_seen = 1'b0;
	wire csel_n, sck, si, so, so_oe, write_enable_latch, busy, ppen, stby, irst;
	wire [1:0] bp;
	integer fail_count, n_compared, cyc, seed, i, wel_m, bp_m;
	logic [15:0] a;
	logic [7:0] r, d;
	int mem[int];
	eersd_core #(.WRITE_CYCLES(WC)) dut (.clk_i(clk_i), .rst_i(rst_i), .csel_n_i(csel_n), .sck_i(sck),
		.si_i(si), .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe), .write_enable_latch_o(write_enable_latch), .busy_o(busy),
		.protect_pin_enable_o(ppen), .block_protect_o(bp), .standby_o(stby), .iface_reset_o(irst));
	eersd_master m (.clk_i(clk_i), .so_i(so), .so_oe_i(so_oe), .csel_n_o(csel_n), .sck_o(sck), .si_o(si));
	////////////////////////////////////////////////////////////////
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cyc = cyc + 1;
		wp_n_i <= 1'($random(seed));
		if (irst === 1'b1)
			irst_seen <= 1'b1;
		if (cyc == 40000)
		begin
			fail_count = fail_count + 1;
			finish_test;
		end
	end
	task finish_test;
		if (fail_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		n_compared = n_compared + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task frame(input [7:0] op, input bit wa, input [15:0] ad, input [7:0] dt, input integer nb);
		m.sel(1);
		m.xfer(op, 8, r);
		if (wa)
		begin
			m.xfer(ad[15:8], 8, r);
			m.xfer(ad[7:0], 8, r);
		end
		if (nb > 0)
			m.xfer(dt, nb, r);
		m.sel(0);
	endtask
	task status;
		frame(8'h05, 0, 0, 0, 8);
		chk(r, {4'h0, bp_m[1:0], wel_m[0], 1'b0});
	endtask
	task rd_mem;
		frame(8'h03, 1, a, 0, 8);
		chk(r, mem.exists(a) ? mem[a][7:0] : 8'hff);
	endtask
	task wait_idle;
		for (i = 0; i < 500 && busy !== 1'b0; i = i + 1)
			@(posedge clk_i);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		seed = 32'h61e0;
		fail_count = 0;
		n_compared = 0;
		cyc = 0;
		wel_m = 0;
		bp_m = 0;
		rst_i = 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({2'h0, stby, busy, write_enable_latch, ppen, bp}, 8'h20);
		repeat (PUP_CYC) @(posedge clk_i);
		status;
		a = $random(seed) & 16'h3fff;
		rd_mem;
		m.sel(1);
		m.sel(0);
		chk({7'h0, irst_seen}, 8'h01);
		frame(8'h0e, 0, 0, 0, 0);
		frame(8'h02, 1, a, 8'h00, 4);
		m.sel(1);
		m.sel(0);
		chk({7'h0, busy}, 8'h00);
		rd_mem;
		frame(8'h06, 0, 0, 0, 0);
		wel_m = 1;
		status;
		d = $random(seed);
		frame(8'h02, 1, a, d, 8);
		chk({7'h0, busy}, 8'h01);
		wait_idle;
		mem[a] = d;
		wel_m = 0;
		rd_mem;
		frame(8'h06, 0, 0, 0, 0);
		frame(8'h0c, 0, 0, 0, 0);
		status;
		frame(8'h06, 0, 0, 0, 0);
		frame(8'h01, 0, 0, 8'h08, 8);
		wait_idle;
		bp_m = 2;
		status;
		frame(8'h06, 0, 0, 0, 0);
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		frame(8'h06, 0, 0, 0, 0);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({2'h0, stby, busy, write_enable_latch, ppen, bp}, 8'h22);
		frame(8'h06, 0, 0, 0, 0);
		frame(8'h02, 1, 16'h7f00, d, 8);
		chk({7'h0, busy}, 8'h00);
		a = 16'h7f00;
		rd_mem;
		finish_test;
	end
endmodule
bind eersd_core eersd_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.csel_n_i(csel_n_i), .sck_i(sck_i), .si_i(si_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
	.write_enable_latch_o(write_enable_latch_o), .busy_o(busy_o), .protect_pin_enable_o(protect_pin_enable_o),
	.block_protect_o(block_protect_o), .standby_o(standby_o), .iface_reset_o(iface_reset_o));
